// *** src/aaa_regs.svh ***
// Sizes, length limits, field widths and source codes for the archive access arbiter.
`ifndef AAA_REGS_SVH
`define AAA_REGS_SVH

// Data word carried on every port, in bits.
`define AAA_WORD_BITS        32
// Standard system block, in bits, and the same block counted in words.
`define AAA_BLOCK_BITS       2048
`define AAA_BLOCK_WORDS      (`AAA_BLOCK_BITS / `AAA_WORD_BITS)
`define AAA_BLOCK_LAST_IDX   6'h3F
`define AAA_WIDX_BITS        6
// Instrument packet length limits, in bits, and rounded up to whole words.
`define AAA_PKT_MIN_BITS     256
`define AAA_PKT_MAX_BITS     8388577
`define AAA_PKT_MIN_WORDS    ((`AAA_PKT_MIN_BITS + `AAA_WORD_BITS - 1) / `AAA_WORD_BITS)
`define AAA_PKT_MAX_WORDS    ((`AAA_PKT_MAX_BITS + `AAA_WORD_BITS - 1) / `AAA_WORD_BITS)
// Packet word counter width; it saturates at its all-ones value.
`define AAA_PCNT_BITS        19
`define AAA_PCNT_SAT         19'h7_FFFF
// Archive write source codes.
`define AAA_SRC_STAGING      1'b0
`define AAA_SRC_BUS          1'b1

`endif

// *** src/aaa_pkg.sv ***
// Types shared by the archive access arbiter modules.
package aaa_pkg;

   // Who holds the archive write path.
   typedef enum logic [1:0] {
      AAA_ST_IDLE   = 2'b00,
      AAA_ST_STG    = 2'b01,
      AAA_ST_BUS_WR = 2'b10
   } aaa_state_e;

   // Kind of bus transfer started by the configuration manager.
   typedef enum logic [1:0] {
      AAA_XFER_ARC_WRITE = 2'b00,
      AAA_XFER_ARC_READ  = 2'b01,
      AAA_XFER_OTHER     = 2'b10
   } aaa_xfer_e;

   typedef logic [31:0] aaa_word_t;

endpackage

// *** src/aaa_blk_if.sv ***
// Block and packet counting signals between the arbiter and its counters.
`timescale 1ns/100ps
`include "aaa_regs.svh"

interface aaa_blk_if;
   logic                         beat;
   logic                         clear;
   logic [`AAA_WIDX_BITS-1:0]    word_idx;
   logic                         block_end;
   logic                         first_block;
   logic [`AAA_PCNT_BITS-1:0]    words;

   modport ctl (output beat, output clear,
                input word_idx, input block_end, input first_block, input words);
   modport cnt (input beat, input clear,
                output word_idx, output block_end, output first_block, output words);
endinterface

// *** src/aaa_block_counter.sv ***
// Word counter that splits a transfer into standard blocks.
`timescale 1ns/100ps
`include "aaa_regs.svh"

module aaa_block_counter (
   input wire logic clk,
   input wire logic resetn,
   aaa_blk_if.cnt   blk
);
   import aaa_pkg::*;

   logic [`AAA_WIDX_BITS-1:0] word_reg;
   logic [`AAA_WIDX_BITS-1:0] word_next;
   logic [`AAA_PCNT_BITS-1:0] total_reg;
   logic [`AAA_PCNT_BITS-1:0] total_next;

   // The block ends on the beat that fills the last word slot of it.
   assign blk.block_end   = blk.beat && (word_reg == `AAA_BLOCK_LAST_IDX);
   assign blk.word_idx    = word_reg;
   assign blk.words       = total_reg;
   assign blk.first_block = (total_reg < `AAA_PCNT_BITS'(`AAA_BLOCK_WORDS));

   // Word slot wraps at the block size; the total saturates so a runaway
   // packet cannot wrap back into the legal range.
   assign word_next  = blk.clear ? '0 :
                       blk.beat  ? word_reg + `AAA_WIDX_BITS'(1) : word_reg;
   assign total_next = blk.clear ? '0 :
                       (blk.beat && total_reg != `AAA_PCNT_SAT) ?
                          total_reg + `AAA_PCNT_BITS'(1) : total_reg;

   // Count registers.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         word_reg  <= '0;
         total_reg <= '0;
      end else begin
         word_reg  <= word_next;
         total_reg <= total_next;
      end
   end

endmodule

// *** src/aaa_arbiter.sv ***
// Archive store access arbiter between the staging port and the system bus.
//
// How it works
// - Staging transfers undisturbed by other bus traffic.
// - Staging port starts its own archive transfers.
// - Other transfers start only after manager start.
// - Only one source writes archive at once.
// - On contention the staging port wins.
// - Packets of 256 bits to 8 megabits forwarded whole.
// - All data split into 2048-bit blocks.
// - Header beyond first block never reaches aux storage.
// - Bus moves archive data directly, no copy.
// - Non-archive-write bus transfers run alongside staging.
// - One controller sequences every bus block.
`timescale 1ns/100ps
`include "aaa_regs.svh"

module aaa_arbiter (
   input  wire logic                 clk,
   input  wire logic                 resetn,
   // Staging port stream.
   input  wire logic                 stg_req,
   input  wire logic                 stg_valid,
   input  wire aaa_pkg::aaa_word_t   stg_data,
   input  wire logic                 stg_last,
   output logic                      stg_ready,
   output logic                      stg_active,
   output logic                      stg_pkt_done,
   output logic                      stg_len_err,
   // Configuration manager transfer start and bus stream.
   input  wire logic                 cms_start,
   input  wire aaa_pkg::aaa_xfer_e   cms_kind,
   output logic                      bus_busy,
   output logic                      bus_done,
   input  wire logic                 bus_valid,
   input  wire aaa_pkg::aaa_word_t   bus_data,
   input  wire logic                 bus_last,
   output logic                      bus_ready,
   output logic                      bus_out_valid,
   output aaa_pkg::aaa_word_t        bus_out_data,
   output logic                      bus_out_last,
   output logic                      bus_blk_end,
   // Archive store write port.
   output logic                      arc_wr_valid,
   output aaa_pkg::aaa_word_t        arc_wr_data,
   output logic                      arc_wr_src,
   output logic                      arc_wr_last,
   output logic                      arc_wr_blk_end,
   input  wire logic                 arc_wr_ready,
   // Archive store read port.
   output logic                      arc_rd_req,
   input  wire logic                 arc_rd_valid,
   input  wire aaa_pkg::aaa_word_t   arc_rd_data,
   input  wire logic                 arc_rd_last,
   // Header copy toward auxiliary storage.
   output logic                      aux_hdr_valid,
   output aaa_pkg::aaa_word_t        aux_hdr_data
);
   import aaa_pkg::*;

   aaa_blk_if stg_blk ();
   aaa_blk_if bus_blk ();

   aaa_state_e                state_reg;
   aaa_state_e                state_next;
   logic                      busy_reg;
   logic                      busy_next;
   aaa_xfer_e                 kind_reg;
   aaa_xfer_e                 kind_next;

   logic                      arc_valid_reg;
   aaa_word_t                 arc_data_reg;
   logic                      arc_src_reg;
   logic                      arc_last_reg;
   logic                      arc_blk_end_reg;

   logic                      out_valid_reg;
   aaa_word_t                 out_data_reg;
   logic                      out_last_reg;
   logic                      blk_end_reg;
   logic                      done_reg;
   logic                      pkt_done_reg;
   logic                      len_err_reg;
   logic                      hdr_valid_reg;
   aaa_word_t                 hdr_data_reg;

   wire logic                 out_free;
   wire logic                 grant_stg;
   wire logic                 grant_bus_wr;
   wire logic                 stg_go;
   wire logic                 bus_wr_go;
   wire logic                 other_go;
   wire logic                 rd_go;
   wire logic                 bus_beat;
   wire logic                 bus_end;
   wire logic                 preempt;
   wire logic                 start_ok;
   wire logic [`AAA_PCNT_BITS-1:0] pkt_words;
   wire logic                 len_bad;

   // Returns true when a whole packet word count falls outside the limits.
   function automatic logic aaa_len_bad(input logic [`AAA_PCNT_BITS-1:0] words);
      aaa_len_bad = (words < `AAA_PCNT_BITS'(`AAA_PKT_MIN_WORDS)) ||
                    (words > `AAA_PCNT_BITS'(`AAA_PKT_MAX_WORDS));
   endfunction

   // Block counters for the staging packet and for the current bus transfer.
   aaa_block_counter u_stg_cnt (
      .clk    (clk),
      .resetn (resetn),
      .blk    (stg_blk.cnt)
   );

   aaa_block_counter u_bus_cnt (
      .clk    (clk),
      .resetn (resetn),
      .blk    (bus_blk.cnt)
   );

   // The archive write stage takes a new word when empty or draining.
   assign out_free     = !arc_valid_reg || arc_wr_ready;
   // Grants come straight from the single state register, so at most one
   // source can ever own the write stage.
   assign grant_stg    = (state_reg == AAA_ST_STG);
   assign grant_bus_wr = (state_reg == AAA_ST_BUS_WR);

   // Staging words move on their own handshake, with no manager command.
   assign stg_go       = grant_stg && stg_valid && out_free;
   assign bus_wr_go    = grant_bus_wr && bus_valid && out_free;
   // Non-write bus kinds never touch the write stage, so they are allowed
   // to run while staging owns the archive.
   assign other_go     = busy_reg && (kind_reg == AAA_XFER_OTHER) && bus_valid;
   assign rd_go        = busy_reg && (kind_reg == AAA_XFER_ARC_READ) && arc_rd_valid;
   assign bus_beat     = bus_wr_go || other_go || rd_go;
   assign bus_end      = (bus_wr_go && bus_last) || (other_go && bus_last) ||
                         (rd_go && arc_rd_last);
   // A waiting staging request takes over only on a bus block boundary.
   assign preempt      = bus_wr_go && !bus_last && bus_blk.block_end && stg_req;
   // Bus transfers exist only once the manager starts one.
   assign start_ok     = cms_start && !busy_reg;

   // Counter controls: staging counts restart between packets.
   assign stg_blk.beat  = stg_go;
   assign stg_blk.clear = (state_reg == AAA_ST_IDLE);
   assign bus_blk.beat  = bus_beat;
   assign bus_blk.clear = !busy_reg;

   // Packet size includes the word taken in the closing beat.
   assign pkt_words = (stg_blk.words == `AAA_PCNT_SAT) ? stg_blk.words :
                      stg_blk.words + `AAA_PCNT_BITS'(1);
   assign len_bad   = aaa_len_bad(pkt_words);

   // Arbitration: staging beats a pending bus write when both wait.
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         AAA_ST_IDLE: begin
            if (stg_req) begin
               state_next = AAA_ST_STG;
            end else if (busy_reg && kind_reg == AAA_XFER_ARC_WRITE) begin
               state_next = AAA_ST_BUS_WR;
            end
         end
         AAA_ST_STG: begin
            if (stg_go && stg_last) begin
               state_next = AAA_ST_IDLE;
            end
         end
         AAA_ST_BUS_WR: begin
            if ((bus_wr_go && bus_last) || preempt) begin
               state_next = AAA_ST_IDLE;
            end
         end
         default: begin
            state_next = AAA_ST_IDLE;
         end
      endcase
   end

   // Bus transfer bookkeeping; a start while busy is ignored.
   always_comb begin
      busy_next = busy_reg;
      kind_next = kind_reg;
      if (bus_end) begin
         busy_next = 1'b0;
      end else if (start_ok) begin
         busy_next = 1'b1;
         kind_next = cms_kind;
      end
   end

   // Arbiter state and bus transfer registers.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= AAA_ST_IDLE;
         busy_reg  <= 1'b0;
         kind_reg  <= AAA_XFER_ARC_WRITE;
         done_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         busy_reg  <= busy_next;
         kind_reg  <= kind_next;
         done_reg  <= bus_end;
      end
   end

   // Archive write stage holds one word and its tags until accepted.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         arc_valid_reg   <= 1'b0;
         arc_data_reg    <= 32'h0000_0000;
         arc_src_reg     <= `AAA_SRC_STAGING;
         arc_last_reg    <= 1'b0;
         arc_blk_end_reg <= 1'b0;
      end else if (out_free) begin
         arc_valid_reg   <= stg_go || bus_wr_go;
         arc_data_reg    <= stg_go ? stg_data : bus_data;
         arc_src_reg     <= stg_go ? `AAA_SRC_STAGING : `AAA_SRC_BUS;
         arc_last_reg    <= stg_go ? stg_last : (bus_wr_go && bus_last);
         arc_blk_end_reg <= stg_go ? (stg_blk.block_end || stg_last) :
                            (bus_blk.block_end || bus_last);
      end
   end

   // Archive read data goes straight onto the bus, no staging copy.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         out_valid_reg <= 1'b0;
         out_data_reg  <= 32'h0000_0000;
         out_last_reg  <= 1'b0;
         blk_end_reg   <= 1'b0;
      end else begin
         out_valid_reg <= rd_go;
         out_data_reg  <= rd_go ? arc_rd_data : out_data_reg;
         out_last_reg  <= rd_go && arc_rd_last;
         blk_end_reg   <= bus_beat && (bus_blk.block_end || bus_end);
      end
   end

   // Packet end status and the header copy for auxiliary storage.
   // Only words of the first block are copied, so an oversize header
   // stays in the archive and must be read back from there.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pkt_done_reg  <= 1'b0;
         len_err_reg   <= 1'b0;
         hdr_valid_reg <= 1'b0;
         hdr_data_reg  <= 32'h0000_0000;
      end else begin
         pkt_done_reg  <= stg_go && stg_last;
         len_err_reg   <= stg_go && stg_last && len_bad;
         hdr_valid_reg <= stg_go && stg_blk.first_block;
         hdr_data_reg  <= stg_go ? stg_data : hdr_data_reg;
      end
   end

   // Handshakes are combinational so a stalled archive stalls its source.
   assign stg_ready  = grant_stg && out_free;
   assign bus_ready  = (kind_reg == AAA_XFER_OTHER) ? busy_reg :
                       (grant_bus_wr && out_free);
   // Staging activity is shown so the manager holds off archive writes.
   assign stg_active = grant_stg || stg_req;
   assign arc_rd_req = busy_reg && (kind_reg == AAA_XFER_ARC_READ);
   assign bus_busy   = busy_reg;
   assign bus_done   = done_reg;

   // Registered outputs.
   assign stg_pkt_done   = pkt_done_reg;
   assign stg_len_err    = len_err_reg;
   assign arc_wr_valid   = arc_valid_reg;
   assign arc_wr_data    = arc_data_reg;
   assign arc_wr_src     = arc_src_reg;
   assign arc_wr_last    = arc_last_reg;
   assign arc_wr_blk_end = arc_blk_end_reg;
   assign bus_out_valid  = out_valid_reg;
   assign bus_out_data   = out_data_reg;
   assign bus_out_last   = out_last_reg;
   assign bus_blk_end    = blk_end_reg;
   assign aux_hdr_valid  = hdr_valid_reg;
   assign aux_hdr_data   = hdr_data_reg;

endmodule

// *** dv/aaa_arbiter_props.sv ***
// Concurrent checks on the ports of the archive access arbiter.
`timescale 1ns/100ps
`include "aaa_regs.svh"
module aaa_arbiter_props (
   input wire logic               clk,
   input wire logic               resetn,
   input wire logic               stg_req,
   input wire logic               stg_valid,
   input wire aaa_pkg::aaa_word_t stg_data,
   input wire logic               stg_last,
   input wire logic               stg_ready,
   input wire logic               stg_pkt_done,
   input wire logic               stg_len_err,
   input wire logic               cms_start,
   input wire aaa_pkg::aaa_xfer_e cms_kind,
   input wire logic               bus_busy,
   input wire logic               bus_ready,
   input wire logic               arc_wr_valid,
   input wire aaa_pkg::aaa_word_t arc_wr_data,
   input wire logic               arc_wr_src,
   input wire logic               arc_wr_blk_end,
   input wire logic               arc_rd_valid,
   input wire aaa_pkg::aaa_word_t arc_rd_data,
   input wire logic               bus_out_valid,
   input wire aaa_pkg::aaa_word_t bus_out_data,
   input wire logic               aux_hdr_valid
);
   import aaa_pkg::*;
   aaa_xfer_e   kind_reg;
   logic [19:0] wcnt_reg;
   wire         sbeat = stg_valid & stg_ready;
   // Latched kind and staging word count, kept apart from the design's own counters.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         kind_reg <= AAA_XFER_ARC_WRITE;
         wcnt_reg <= 20'h0_0000;
      end else begin
         if (cms_start && !bus_busy) kind_reg <= cms_kind;
         if (sbeat) wcnt_reg <= stg_last ? 20'h0_0000 : wcnt_reg + 20'h0_0001;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   one_writer_a: assert property (!(stg_ready && bus_ready && kind_reg == AAA_XFER_ARC_WRITE))
      else $error("two sources enabled to write the archive");
   stg_first_a: assert property (stg_req && $past(stg_ready) && kind_reg == AAA_XFER_ARC_WRITE
      |-> !bus_ready) else $error("bus write enabled while staging holds the archive");
   self_start_a: assert property ($rose(stg_req) && !bus_busy && !arc_wr_valid |=> stg_ready)
      else $error("staging request not granted from idle");
   fwd_word_a: assert property (sbeat |=> arc_wr_valid && arc_wr_src == `AAA_SRC_STAGING
      && arc_wr_data == $past(stg_data)) else $error("staging word not forwarded");
   blk_end_a: assert property (sbeat && (stg_last || wcnt_reg[5:0] == 6'h3F) |=> arc_wr_blk_end)
      else $error("block end not marked");
   hdr_copy_a: assert property (sbeat |=> aux_hdr_valid == ($past(wcnt_reg) < 20'h0_0040))
      else $error("header copy outside the first block");
   len_flag_a: assert property (sbeat && stg_last |=> stg_pkt_done && stg_len_err ==
      ($past(wcnt_reg) + 1 < `AAA_PKT_MIN_WORDS || $past(wcnt_reg) + 1 > `AAA_PKT_MAX_WORDS))
      else $error("packet end or length flag wrong");
   bus_start_a: assert property ($rose(bus_busy) |-> $past(cms_start))
      else $error("bus transfer without a manager start");
   rd_pass_a: assert property (arc_rd_valid |=> bus_out_valid && bus_out_data == $past(arc_rd_data))
      else $error("archive read word not passed to the bus");
   other_run_a: assert property (bus_busy && kind_reg == AAA_XFER_OTHER |-> bus_ready)
      else $error("other transfer held back");
endmodule
bind aaa_arbiter aaa_arbiter_props u_aaa_arbiter_props (.*);

// *** dv/aaa_archive_model.sv ***
// Archive store model: write acceptance at full or half rate and a short read stream.
`timescale 1ns/100ps
module aaa_archive_model #(
   parameter int RD_WORDS = 5
) (
   input  wire logic          clk,
   input  wire logic          resetn,
   input  wire logic          slow,
   input  wire logic          arc_rd_req,
   output logic               arc_wr_ready,
   output logic               arc_rd_valid,
   output aaa_pkg::aaa_word_t arc_rd_data,
   output logic               arc_rd_last
);
   import aaa_pkg::*;
   int   rd_cnt;
   logic tick_reg;
   // In slow mode a word is taken only every other cycle, to stall the write stage.
   assign arc_wr_ready = !slow || tick_reg;
   // Read words come straight from the store; idle data is scrambled so it is never trusted.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tick_reg <= 1'b0;
         rd_cnt <= 0;
         arc_rd_valid <= 1'b0;
         arc_rd_data <= 32'h0000_0000;
         arc_rd_last <= 1'b0;
      end else begin
         tick_reg <= !tick_reg;
         arc_rd_valid <= arc_rd_req && rd_cnt < RD_WORDS;
         arc_rd_last <= arc_rd_req && rd_cnt == RD_WORDS - 1;
         arc_rd_data <= (arc_rd_req && rd_cnt < RD_WORDS) ? 32'hC000_0000 | rd_cnt : ~arc_rd_data;
         rd_cnt <= !arc_rd_req ? 0 : (rd_cnt < RD_WORDS ? rd_cnt + 1 : rd_cnt);
      end
   end
endmodule

// *** dv/archive_access_arbiter_test.sv ***
// Self-checking bench for the archive access arbiter.
`timescale 1ns/100ps
module archive_access_arbiter_test;
   import aaa_pkg::*;
   logic clk = 0, resetn = 0, slow = 0, stg_req = 0, stg_valid = 0, stg_last = 0;
   logic cms_start = 0, bus_valid = 0, bus_last = 0;
   aaa_word_t stg_data = '0, bus_data = '0, arc_wr_data, arc_rd_data, bus_out_data, aux_hdr_data;
   aaa_xfer_e cms_kind = AAA_XFER_ARC_WRITE;
   logic stg_ready, stg_active, stg_pkt_done, stg_len_err, bus_busy, bus_done, bus_ready;
   logic bus_out_valid, bus_out_last, bus_blk_end, arc_wr_valid, arc_wr_src, arc_wr_last;
   logic arc_wr_blk_end, arc_wr_ready, arc_rd_req, arc_rd_valid, arc_rd_last, aux_hdr_valid;
   int num_errors = 0, check_count = 0, cyc = 0;
   int sn, bn, rn, an, bus_first, done_n, err_n, bd_n, lw, bb_n;
   aaa_arbiter u_aaa_arbiter (.*);
   aaa_archive_model u_aaa_archive_model (.*);
   always #5 clk = ~clk;
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask
   task automatic end_sim();
      $display("errors %0d, checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Scoreboard: each archive word must carry the next pattern of its own source.
   always @(posedge clk) begin
      cyc++;
      if (arc_wr_valid === 1'b1 && arc_wr_ready === 1'b1) begin
         if (arc_wr_src === 1'b0) begin
            if (bus_first < 0) bus_first = bn;
            chk("arc_stg", 32'h5A00_0000 | sn, arc_wr_data);
            sn++;
         end else begin
            chk("arc_bus", 32'hB000_0000 | bn, arc_wr_data);
            bn++;
         end
         if (arc_wr_last === 1'b1) lw++;
      end
      if (bus_out_valid === 1'b1) begin
         chk("rd_word", 32'hC000_0000 | rn, bus_out_data);
         chk("rd_last", rn == 4, bus_out_last);
         rn++;
      end
      // Header copies must be the opening words of the packet, in order.
      if (aux_hdr_valid === 1'b1) begin
         chk("hdr_data", 32'h5A00_0000 | an, aux_hdr_data);
         an++;
      end
      if (bus_blk_end === 1'b1) bb_n++;
      if (stg_pkt_done === 1'b1) done_n++;
      if (stg_len_err === 1'b1) err_n++;
      if (bus_done === 1'b1) bd_n++;
      if (cyc == 6000) begin
         num_errors++;
         end_sim();
      end
   end
   task automatic clr();
      {sn, bn, rn, an, done_n, err_n, bd_n, lw, bb_n} = '0;
      bus_first = -1;
   endtask
   // Streams n pattern words from one source, holding each until it is taken.
   task automatic send(input bit to_bus, input int n);
      int   i;
      logic ok;
      i = 0;
      if (!to_bus) stg_req <= 1'b1;
      while (i < n) begin
         if (to_bus) begin
            bus_valid <= 1'b1;
            bus_data <= 32'hB000_0000 | i;
            bus_last <= (i == n - 1);
         end else begin
            stg_valid <= 1'b1;
            stg_data <= 32'h5A00_0000 | i;
            stg_last <= (i == n - 1);
         end
         @(negedge clk);
         ok = to_bus ? bus_ready : stg_ready;
         if (!to_bus) chk("stg_active", 1, stg_active);
         @(posedge clk);
         if (ok === 1'b1) i++;
      end
      // Release only this source's signals; the other source may still be streaming.
      if (to_bus) begin
         {bus_valid, bus_last} <= 2'b00;
         bus_data <= ~bus_data;
      end else begin
         {stg_valid, stg_last, stg_req} <= 3'b000;
         stg_data <= ~stg_data;
      end
   endtask
   // The manager holds off an archive write while the staging port is active.
   task automatic start_bus(input aaa_xfer_e k);
      while (k == AAA_XFER_ARC_WRITE && stg_active === 1'b1) @(posedge clk);
      cms_start <= 1'b1;
      cms_kind <= k;
      @(posedge clk);
      cms_start <= 1'b0;
   endtask
   task automatic drain();
      for (int i = 0; i < 400 && (bus_busy !== 1'b0 || arc_wr_valid !== 1'b0); i++) @(posedge clk);
      repeat (3) @(posedge clk);
   endtask
   // One packet of n words, with the store stalling when s is set.
   task automatic t_length(input int n, input bit s);
      clr();
      slow <= s;
      send(1'b0, n);
      drain();
      chk("stg_words", n, sn);
      chk("hdr_words", n < 64 ? n : 64, an);
      chk("len_err", n < 8, err_n);
      chk("pkt_done", 1, done_n);
      chk("arc_last", 1, lw);
      chk("stg_active_idle", 0, stg_active);
   endtask
   // Staging and a bus write start on the same edge; staging goes first.
   task automatic t_contend();
      clr();
      slow <= 1'b0;
      fork
         begin
            start_bus(AAA_XFER_ARC_WRITE);
            send(1'b1, 70);
         end
         send(1'b0, 20);
      join
      drain();
      chk("bus_before_stg", 0, bus_first);
      chk("bus_words", 70, bn);
      chk("stg_words", 20, sn);
      chk("arc_last", 2, lw);
      chk("bus_blk_ends", 2, bb_n);
   endtask
   // Staging asks in mid block of a bus write and takes over at the block end.
   task automatic t_preempt();
      clr();
      slow <= 1'b1;
      fork
         begin
            start_bus(AAA_XFER_ARC_WRITE);
            send(1'b1, 130);
         end
         begin
            repeat (10) @(posedge clk);
            send(1'b0, 9);
         end
      join
      drain();
      chk("bus_before_stg", 64, bus_first);
      chk("bus_words", 130, bn);
      chk("bus_blk_ends", 3, bb_n);
      chk("stg_words", 9, sn);
   endtask
   // A read or other bus transfer runs beside a staging packet.
   task automatic t_beside(input aaa_xfer_e k);
      clr();
      slow <= 1'b0;
      fork
         begin
            start_bus(k);
            if (k == AAA_XFER_OTHER) send(1'b1, 3);
         end
         send(1'b0, 12);
      join
      drain();
      chk("rd_words", k == AAA_XFER_ARC_READ ? 5 : 0, rn);
      chk("bus_words", 0, bn);
      chk("stg_words", 12, sn);
      chk("bus_done", 1, bd_n);
   endtask
   initial begin
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      t_length(7, 1'b0);
      t_length(8, 1'b0);
      t_length(130, 1'b1);
      t_contend();
      t_preempt();
      t_beside(AAA_XFER_ARC_READ);
      t_beside(AAA_XFER_OTHER);
      end_sim();
   end
endmodule
